// ===== src/wlc_top.sv
// wlc_top: window limit checker with apb registers, ttl outputs and a failure interrupt
// assumes measurement strobes and results come from logic on the same 25 MHz clock
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wlc_cfg.svh"
// Operation
// - flag results outside window upper/lower limits
// - dB limits -180..+200, defaults 60/-120
// - dBm limits -150..+230, defaults 90/-90
// - independent limits, checked only when enabled
// - disabled ttl output stays inactive
// - ttl polarity selects active high or low
// - ttl source: over, under or either
// - ttl follows window one, two or both
// - failure flag reads 1 after any failure
// - per-window running failure count readable
// - with auto delay only settled results count
// - failure raises service request interrupt
// - channel and window limits never both on
module wlc_top #(
    parameter int CNT_W = `WLC_CNT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement results per window
    input wire logic [1:0] meas_valid,
    input wire logic [1:0] meas_settled,
    input wire wlc_pkg::wlc_word_t meas_result1,
    input wire wlc_pkg::wlc_word_t meas_result2,
    // outputs
    output logic [1:0] ttl_out,
    output logic chan_limits_on,
    output logic irq
);
    import wlc_pkg::*;

    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
        $error("wlc_top: CNT_W must lie in 2..32");
    end

    // =========================================================
    // state
    logic [1:0] win_en;
    logic auto_dly;
    logic [1:0] unit_sel;
    logic clr_pulse;
    wlc_word_t lim_lo [2];
    wlc_word_t lim_hi [2];
    logic [15:0] ttl_cfg;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] over;
    logic [1:0] under;
    logic [1:0] fail;
    logic [1:0] fail_evt;
    logic [CNT_W-1:0] count [2];

    // =========================================================
    // bus decode
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic wr_bad;
    logic [31:0] rdata;
    wlc_word_t wval;
    assign acc = psel && penable && pready;
    assign wr_acc = acc && pwrite && !wr_bad;
    assign rd_acc = acc && !pwrite;
    assign wval = wlc_word_t'(pwdata);

    function automatic logic in_range(input logic dbm, input wlc_word_t v);
        if (dbm) begin
            return v >= `WLC_DBM_MIN && v <= `WLC_DBM_MAX;
        end
        return v >= `WLC_DB_MIN && v <= `WLC_DB_MAX;
    endfunction : in_range

    always_comb begin
        mapped = 1'b1;
        wr_bad = 1'b0;
        rdata = 32'h00000000;
        if (paddr == `WLC_OFF_CTRL) begin
            rdata = {26'h0000000, unit_sel, auto_dly, chan_limits_on, win_en};
            wr_bad = pwrite && (|pwdata[`WLC_CTRL_WEN +: 2]) && pwdata[`WLC_CTRL_CEN];
        end else if (paddr == `WLC_OFF_LOW1) begin
            rdata = lim_lo[0];
            wr_bad = pwrite && !in_range(unit_sel[0], wval);
        end else if (paddr == `WLC_OFF_UPP1) begin
            rdata = lim_hi[0];
            wr_bad = pwrite && !in_range(unit_sel[0], wval);
        end else if (paddr == `WLC_OFF_LOW2) begin
            rdata = lim_lo[1];
            wr_bad = pwrite && !in_range(unit_sel[1], wval);
        end else if (paddr == `WLC_OFF_UPP2) begin
            rdata = lim_hi[1];
            wr_bad = pwrite && !in_range(unit_sel[1], wval);
        end else if (paddr == `WLC_OFF_TTL) begin
            rdata = {16'h0000, ttl_cfg};
        end else if (paddr == `WLC_OFF_FAIL) begin
            rdata = {26'h0000000, under, over, fail};
        end else if (paddr == `WLC_OFF_CNT1) begin
            rdata = 32'(count[0]);
        end else if (paddr == `WLC_OFF_CNT2) begin
            rdata = 32'(count[1]);
        end else if (paddr == `WLC_OFF_IST) begin
            rdata = {30'h00000000, irq_stat};
        end else if (paddr == `WLC_OFF_IMSK) begin
            rdata = {30'h00000000, irq_mask};
        end else begin
            mapped = 1'b0;
            wr_bad = pwrite;
        end
    end

    // =========================================================
    // apb handshake: one wait cycle, answer registered
    always_ff @(posedge clock) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= !mapped || wr_bad;
                prdata <= pwrite ? 32'h00000000 : rdata;
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // =========================================================
    // control register
    always_ff @(posedge clock) begin
        if (srst) begin
            win_en <= 2'h0;
            chan_limits_on <= 1'b0;
            auto_dly <= 1'(`WLC_CTRL_RST >> `WLC_CTRL_ADLY);
            unit_sel <= 2'(`WLC_CTRL_RST >> `WLC_CTRL_UNIT);
            clr_pulse <= 1'b0;
        end else begin
            clr_pulse <= wr_acc && paddr == `WLC_OFF_CTRL && pwdata[`WLC_CTRL_CLR];
            if (wr_acc && paddr == `WLC_OFF_CTRL) begin
                win_en <= pwdata[`WLC_CTRL_WEN +: 2];
                chan_limits_on <= pwdata[`WLC_CTRL_CEN];
                auto_dly <= pwdata[`WLC_CTRL_ADLY];
                unit_sel <= pwdata[`WLC_CTRL_UNIT +: 2];
            end
        end
    end

    // =========================================================
    // limit registers, defaults reloaded on reset or unit change
    logic unit_wr;
    assign unit_wr = wr_acc && paddr == `WLC_OFF_CTRL;
    generate
        for (genvar i = 0; i < 2; i++) begin : g_lim
            logic new_dbm;
            assign new_dbm = srst ? 1'(`WLC_CTRL_RST >> (`WLC_CTRL_UNIT + i)) : pwdata[`WLC_CTRL_UNIT + i];
            always_ff @(posedge clock) begin
                if (srst || (unit_wr && new_dbm != unit_sel[i])) begin
                    lim_hi[i] <= new_dbm ? `WLC_DBM_UPP : `WLC_DB_UPP;
                    lim_lo[i] <= new_dbm ? `WLC_DBM_LOW : `WLC_DB_LOW;
                end else if (wr_acc && paddr == `WLC_OFF_LOW1 + 12'(8 * i)) begin
                    lim_lo[i] <= wval;
                end else if (wr_acc && paddr == `WLC_OFF_UPP1 + 12'(8 * i)) begin
                    lim_hi[i] <= wval;
                end
            end
        end
    endgenerate

    // =========================================================
    // window checkers
    wlc_win_if #(.CW(CNT_W)) w_if [2] ();
    generate
        for (genvar i = 0; i < 2; i++) begin : g_win
            assign w_if[i].en = win_en[i];
            assign w_if[i].auto_dly = auto_dly;
            assign w_if[i].clr = clr_pulse;
            assign w_if[i].valid = meas_valid[i];
            assign w_if[i].settled = meas_settled[i];
            assign w_if[i].result = (i == 0) ? meas_result1 : meas_result2;
            assign w_if[i].lo = lim_lo[i];
            assign w_if[i].hi = lim_hi[i];
            assign over[i] = w_if[i].over;
            assign under[i] = w_if[i].under;
            assign fail[i] = w_if[i].fail;
            assign fail_evt[i] = w_if[i].fail_evt;
            assign count[i] = w_if[i].count;
            wlc_win #(.CW(CNT_W)) u_win (
                .clock(clock),
                .srst(srst),
                .w(w_if[i])
            );
        end
    endgenerate

    // =========================================================
    // ttl configuration and outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            ttl_cfg <= `WLC_TTL_RST;
        end else if (wr_acc && paddr == `WLC_OFF_TTL) begin
            ttl_cfg <= pwdata[15:0];
        end
    end

    generate
        for (genvar t = 0; t < 2; t++) begin : g_ttl
            logic [7:0] cfg;
            logic over_sel;
            logic under_sel;
            logic cond;
            assign cfg = ttl_cfg[8*t +: 8];
            assign over_sel = |(cfg[`WLC_TTL_WIN +: 2] & over);
            assign under_sel = |(cfg[`WLC_TTL_WIN +: 2] & under);
            assign cond = (cfg[`WLC_TTL_SRC] && over_sel) || (cfg[`WLC_TTL_SRC + 1] && under_sel);
            always_ff @(posedge clock) begin
                if (srst) begin
                    ttl_out[t] <= 1'b0;
                end else if (!cfg[`WLC_TTL_EN]) begin
                    ttl_out[t] <= !cfg[`WLC_TTL_POL];
                end else begin
                    ttl_out[t] <= cond ~^ cfg[`WLC_TTL_POL];
                end
            end
        end
    endgenerate

    // =========================================================
    // interrupt status, mask and output
    logic ist_rd;
    assign ist_rd = rd_acc && paddr == `WLC_OFF_IST;
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            irq <= 1'b0;
        end else begin
            // clear only the bits that the read returned, so an event after the snapshot is kept
            irq_stat <= (irq_stat & ~(ist_rd ? prdata[1:0] : 2'h0)) | fail_evt;
            if (wr_acc && paddr == `WLC_OFF_IMSK) begin
                irq_mask <= pwdata[1:0];
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_excl_sets: assert property (!(chan_limits_on && |win_en))
        else $error("channel and window limits both on");
    chk_fail_sticky: assert property (fail[0] && !clr_pulse |=> fail[0])
        else $error("window one failure flag dropped");
    chk_count_sat: assert property (&count[0] |=> &count[0] || count[0] == '0)
        else $error("failure count wrapped");
    chk_fail_count: assert property (meas_valid[0] && win_en[0] && !auto_dly && !clr_pulse
        && meas_result1 > lim_hi[0] && !(&count[0]) |=> count[0] == $past(count[0]) + 1'b1)
        else $error("failure not counted");
    chk_over_flag: assert property (meas_valid[1] && win_en[1] && !auto_dly
        && meas_result2 > lim_hi[1] |=> over[1] && fail[1])
        else $error("over limit not flagged");
    chk_settle_skip: assert property (auto_dly && !meas_settled[0] && !clr_pulse |=> $stable(count[0]))
        else $error("unsettled result counted");
    chk_off_window: assert property (!win_en[1] && !clr_pulse |=> $stable(count[1]) && !over[1])
        else $error("disabled window checked");
    chk_ttl_off: assert property (!ttl_cfg[`WLC_TTL_EN] |=> ttl_out[0] == !$past(ttl_cfg[`WLC_TTL_POL]))
        else $error("disabled ttl output active");
    chk_ttl_pol: assert property (ttl_cfg[`WLC_TTL_EN] && ttl_cfg[`WLC_TTL_POL] && ttl_cfg[`WLC_TTL_SRC]
        && ttl_cfg[`WLC_TTL_WIN] && over[0] |=> ttl_out[0])
        else $error("active high ttl not asserted on over");
    chk_irq_path: assert property (fail_evt[0] && irq_mask[0] && !(wr_acc && paddr == `WLC_OFF_IMSK)
        |-> ##2 irq)
        else $error("masked-in failure gave no interrupt");
    chk_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing broken");
    chk_limit_range: assert property (lim_lo[0] >= `WLC_DB_MIN && lim_hi[0] <= `WLC_DBM_MAX)
        else $error("window one limit out of range");

    cov_fail_evt: cover property (fail_evt[0] ##1 fail[0]);
    cov_ttl_under: cover property (ttl_cfg[`WLC_TTL_EN + 8] && under[1] ##1 ttl_out[1]);
    cov_irq: cover property (irq ##[1:20] !irq);
    cov_bad_write: cover property (pslverr && pwrite);
endmodule : wlc_top
`default_nettype wire

// ===== include/wlc_cfg.svh
// wlc_cfg.svh: register offsets, field positions, reset values and limit bounds of the window limit checker
// assumes limit values are signed hundredths of a decibel
`ifndef WLC_CFG_SVH
`define WLC_CFG_SVH
`define WLC_CNT_W 16
// register byte offsets
`define WLC_OFF_CTRL 12'h000
`define WLC_OFF_LOW1 12'h004
`define WLC_OFF_UPP1 12'h008
`define WLC_OFF_LOW2 12'h00C
`define WLC_OFF_UPP2 12'h010
`define WLC_OFF_TTL 12'h014
`define WLC_OFF_FAIL 12'h018
`define WLC_OFF_CNT1 12'h01C
`define WLC_OFF_CNT2 12'h020
`define WLC_OFF_IST 12'h024
`define WLC_OFF_IMSK 12'h028
// control fields
`define WLC_CTRL_WEN 0
`define WLC_CTRL_CEN 2
`define WLC_CTRL_ADLY 3
`define WLC_CTRL_UNIT 4
`define WLC_CTRL_CLR 8
`define WLC_CTRL_RST 32'h00000038
// ttl fields inside each byte
`define WLC_TTL_EN 0
`define WLC_TTL_POL 1
`define WLC_TTL_SRC 2
`define WLC_TTL_WIN 4
`define WLC_TTL_RST 16'h0202
// limit bounds in hundredths of dB or dBm
`define WLC_DB_MAX 32'sh00004E20
`define WLC_DB_MIN -32'sh00004650
`define WLC_DB_UPP 32'sh00001770
`define WLC_DB_LOW -32'sh00002EE0
`define WLC_DBM_MAX 32'sh000059D8
`define WLC_DBM_MIN -32'sh00003A98
`define WLC_DBM_UPP 32'sh00002328
`define WLC_DBM_LOW -32'sh00002328
`endif

// ===== include/wlc_pkg.sv
// wlc_pkg: types shared by the window limit checker modules
// assumes nothing beyond a SystemVerilog compiler
package wlc_pkg;
    typedef logic signed [31:0] wlc_word_t;
    typedef enum logic {WLC_UNIT_DB = 1'b0, WLC_UNIT_DBM = 1'b1} wlc_unit_t;
endpackage : wlc_pkg

// ===== include/wlc_win_if.sv
// wlc_win_if: signals between the register block and one window checker
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface wlc_win_if #(parameter int CW = 16);
    logic en;
    logic auto_dly;
    logic clr;
    logic valid;
    logic settled;
    wlc_pkg::wlc_word_t result;
    wlc_pkg::wlc_word_t lo;
    wlc_pkg::wlc_word_t hi;
    logic over;
    logic under;
    logic fail;
    logic fail_evt;
    logic [CW-1:0] count;
    modport ctl (output en, auto_dly, clr, valid, settled, result, lo, hi,
                 input over, under, fail, fail_evt, count);
    modport win (input en, auto_dly, clr, valid, settled, result, lo, hi,
                 output over, under, fail, fail_evt, count);
endinterface : wlc_win_if
`default_nettype wire

// ===== src/wlc_win.sv
// wlc_win: limit comparison, sticky failure flag and saturating failure count for one window
// assumes result strobes come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module wlc_win #(
    parameter int CW = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // window link
    wlc_win_if.win w
);
    import wlc_pkg::*;
    if (CW < 2 || CW > 32) begin : g_bad_cw
        $error("wlc_win: CW must lie in 2..32");
    end
    logic check;
    logic fails;
    assign check = w.valid && w.en && (!w.auto_dly || w.settled);
    assign fails = (w.result > w.hi) || (w.result < w.lo);

    // =========================================================
    // current over and under state
    always_ff @(posedge clock) begin
        if (srst || !w.en) begin
            w.over <= 1'b0;
            w.under <= 1'b0;
        end else if (check) begin
            w.over <= w.result > w.hi;
            w.under <= w.result < w.lo;
        end
    end

    // =========================================================
    // sticky flag, count and event
    always_ff @(posedge clock) begin
        if (srst) begin
            w.fail <= 1'b0;
            w.count <= '0;
            w.fail_evt <= 1'b0;
        end else begin
            w.fail_evt <= check && fails;
            if (check && fails) begin
                w.fail <= 1'b1;
                if (w.count != {CW{1'b1}}) begin
                    w.count <= w.count + 1'b1;
                end
            end else if (w.clr) begin
                w.fail <= 1'b0;
                w.count <= '0;
            end
        end
    end
endmodule : wlc_win
`default_nettype wire

// ===== tb/wlc_ttl_sense.sv
// wlc_ttl_sense: external equipment that senses the two ttl outputs
// assumes it knows the polarity each output was programmed with
`timescale 1ns/1ps
`default_nettype none
module wlc_ttl_sense (
    // sensed pins and expected polarity
    input wire logic [1:0] ttl_out,
    input wire logic [1:0] active_high,
    // decoded assertion
    output logic [1:0] asserted
);
    // an output counts as asserted when its level equals the polarity level
    assign asserted = ~(ttl_out ^ active_high);
endmodule : wlc_ttl_sense
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the window limit checker
// assumes the design files and the ttl sense model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "wlc_cfg.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
    import wlc_pkg::*;
    // ==========================================================
    // design and partner
    localparam int CMAX = 15;
    logic clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, chan_limits_on, irq, er, adly = 1'b1;
    logic [1:0] meas_valid = '0, meas_settled = '0, ttl_out, ttl_hi = '0, ttl_act, ov = '0, un = '0, fl = '0;
    logic [5:0] c0, c1;
    wlc_word_t meas_result1 = '0, meas_result2 = '0, lo[2], hi[2];
    int cnt[2], bad_count = 0, checks_done = 0;
    always #20 clock = ~clock;
    wlc_top #(.CNT_W(4)) u_dut (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_valid(meas_valid), .meas_settled(meas_settled), .meas_result1(meas_result1),
        .meas_result2(meas_result2), .ttl_out(ttl_out), .chan_limits_on(chan_limits_on), .irq(irq));
    wlc_ttl_sense u_sense (.ttl_out(ttl_out), .active_high(ttl_hi), .asserted(ttl_act));
    // ==========================================================
    // tasks and expectations
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clock);
            n++;
        end
        if (n >= 16) begin
            bad_count++;
            $display("mismatch pready expected 1 seen %b", pready);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // one idle cycle so a following call never reassigns psel in this time step
        @(posedge clock);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        `CHK("pslverr", e, er);
    endtask : wr
    task rc(input logic [11:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h00000000);
        `CHK(nm, ex, rd);
    endtask : rc
    // one result, then the model decides whether it was checked
    task meas(input int i, input logic st, input wlc_word_t v);
        meas_valid[i] <= 1'b1; meas_settled[i] <= st;
        if (i == 0) meas_result1 <= v;
        else meas_result2 <= v;
        @(posedge clock);
        meas_valid <= 2'b00;
        if ((i == 0 ? adly : adly) == 1'b0 || st) if (cnt[i] >= 0) begin
            if (c0 == 6'h00 || 1) if ((i == 0 && u_en(0)) || (i == 1 && u_en(1))) begin
                ov[i] = v > hi[i];
                un[i] = v < lo[i];
                if (ov[i] | un[i]) begin
                    fl[i] = 1'b1;
                    if (cnt[i] < CMAX) cnt[i]++;
                end
            end
        end
        @(posedge clock);
    endtask : meas
    logic [1:0] wen = 2'b00;
    function automatic logic u_en(input int i);
        return wen[i];
    endfunction : u_en
    function automatic logic ttl_on(input logic [5:0] c);
        return c[0] & (|(c[5:4] & (({2{c[2]}} & ov) | ({2{c[3]}} & un))));
    endfunction : ttl_on
    function automatic logic ttl_exp(input logic [5:0] c);
        return ttl_on(c) ? c[1] : ~c[1];
    endfunction : ttl_exp
    // ==========================================================
    // watchdog and main sequence
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        $display("mismatch watchdog expected done seen hang");
        report_and_stop();
    end
    initial begin
        void'($urandom(77376));
        c0 = 6'h00;
        cnt = '{0, 0};
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        `CHK("ttl_out", 2'b00, ttl_out);
        `CHK("irq", 1'b0, irq);
        rc(`WLC_OFF_CTRL, `WLC_CTRL_RST, "ctrl");
        rc(`WLC_OFF_LOW1, `WLC_DBM_LOW, "low1");
        rc(`WLC_OFF_UPP2, `WLC_DBM_UPP, "upp2");
        rc(`WLC_OFF_TTL, 32'h00000202, "ttl");
        rc(`WLC_OFF_FAIL, 32'h00000000, "fail");
        rc(`WLC_OFF_CNT2, 32'h00000000, "cnt2");
        $display("test reset done");
        wr(`WLC_OFF_CTRL, 32'h00000028, 1'b0);
        rc(`WLC_OFF_LOW1, `WLC_DB_LOW, "low1");
        rc(`WLC_OFF_UPP1, `WLC_DB_UPP, "upp1");
        rc(`WLC_OFF_UPP2, `WLC_DBM_UPP, "upp2");
        wr(`WLC_OFF_UPP1, `WLC_DB_MAX, 1'b0);
        wr(`WLC_OFF_UPP1, (`WLC_DB_MAX + 1), 1'b1);
        wr(`WLC_OFF_LOW1, `WLC_DB_MIN, 1'b0);
        wr(`WLC_OFF_LOW1, (`WLC_DB_MIN - 1), 1'b1);
        rc(`WLC_OFF_UPP1, `WLC_DB_MAX, "upp1");
        wr(`WLC_OFF_UPP2, (`WLC_DBM_MAX + 1), 1'b1);
        wr(`WLC_OFF_LOW2, (`WLC_DBM_MIN - 1), 1'b1);
        wr(`WLC_OFF_LOW2, `WLC_DBM_MIN, 1'b0);
        apb(1'b0, 12'h030, 32'h00000000);
        `CHK("unmapped err", 1'b1, er);
        `CHK("unmapped data", 32'h00000000, rd);
        wr(`WLC_OFF_CTRL, 32'h00000038, 1'b0);
        rc(`WLC_OFF_LOW1, `WLC_DBM_LOW, "low1");
        lo = '{`WLC_DBM_LOW, `WLC_DBM_MIN};
        hi = '{`WLC_DBM_UPP, `WLC_DBM_UPP};
        wr(`WLC_OFF_CTRL, 32'h0000003D, 1'b1);
        wr(`WLC_OFF_CTRL, 32'h0000003C, 1'b0);
        @(posedge clock);
        `CHK("chan_limits_on", 1'b1, chan_limits_on);
        wr(`WLC_OFF_CTRL, 32'h00000038, 1'b0);
        meas(0, 1'b1, 30000);
        wr(`WLC_OFF_CTRL, 32'h0000003B, 1'b0);
        wen = 2'b11;
        meas(0, 1'b0, 30000);
        rc(`WLC_OFF_CNT1, 32'h00000000, "cnt1");
        $display("test setup done");
        for (int i = 0; i < 2; i++) begin
            lo[i] = -$signed($urandom_range(15000));
            hi[i] = $urandom_range(23000);
            wr(12'(4 + 8 * i), lo[i], 1'b0);
            wr(12'(8 + 8 * i), hi[i], 1'b0);
        end
        for (int k = 0; k < 40; k++) begin
            if (k == 20) begin
                wr(`WLC_OFF_CTRL, 32'h00000033, 1'b0);
                adly = 1'b0;
            end
            meas($urandom_range(1), $urandom_range(1), $signed($urandom_range(50000)) - 25000);
        end
        rc(`WLC_OFF_CNT1, 32'(cnt[0]), "cnt1");
        rc(`WLC_OFF_CNT2, 32'(cnt[1]), "cnt2");
        rc(`WLC_OFF_FAIL, {26'h0, un, ov, fl}, "fail");
        $display("test random done");
        apb(1'b0, `WLC_OFF_IST, 32'h00000000);
        wr(`WLC_OFF_IMSK, 32'h00000000, 1'b0);
        meas(0, 1'b1, 30000);
        repeat (3) @(posedge clock);
        `CHK("irq masked", 1'b0, irq);
        rc(`WLC_OFF_IST, 32'h00000001, "ist");
        rc(`WLC_OFF_IST, 32'h00000000, "ist");
        wr(`WLC_OFF_IMSK, 32'h00000003, 1'b0);
        meas(1, 1'b1, 30000);
        repeat (3) @(posedge clock);
        `CHK("irq", 1'b1, irq);
        rc(`WLC_OFF_IST, 32'h00000002, "ist");
        repeat (3) @(posedge clock);
        `CHK("irq cleared", 1'b0, irq);
        $display("test interrupt done");
        wr(`WLC_OFF_CTRL, 32'h00000133, 1'b0);
        cnt = '{0, 0};
        rc(`WLC_OFF_CNT1, 32'h00000000, "cnt1");
        apb(1'b0, `WLC_OFF_FAIL, 32'h00000000);
        `CHK("fail flags", 2'b00, rd[1:0]);
        meas_valid <= 2'b11; meas_settled <= 2'b11; meas_result1 <= 30000; meas_result2 <= 30000;
        repeat (17) @(posedge clock);
        meas_valid <= 2'b00;
        cnt = '{CMAX, CMAX}; ov = 2'b11; un = 2'b00; fl = 2'b11;
        @(posedge clock);
        rc(`WLC_OFF_CNT1, 32'(CMAX), "cnt1");
        rc(`WLC_OFF_CNT2, 32'(CMAX), "cnt2");
        meas(1, 1'b1, -30000);
        rc(`WLC_OFF_CNT2, 32'(CMAX), "cnt2");
        rc(`WLC_OFF_FAIL, {26'h0, un, ov, fl}, "fail");
        $display("test saturate done");
        for (int k = 0; k < 64; k++) begin
            c0 = 6'(k);
            c1 = c0 ^ 6'h2A;
            wr(`WLC_OFF_TTL, {16'h0, 2'b00, c1, 2'b00, c0}, 1'b0);
            ttl_hi <= {c1[1], c0[1]};
            repeat (3) @(posedge clock);
            `CHK("ttl_out", {ttl_exp(c1), ttl_exp(c0)}, ttl_out);
            `CHK("ttl sensed", {ttl_on(c1), ttl_on(c0)}, ttl_act);
        end
        $display("test ttl done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
